// ===== irq_pins_pkg.sv
// Shared constants and carriers for the interrupt and control pin block
package irq_pins_pkg;

  // Number of maskable external interrupt lines
  localparam int unsigned EXT_LINES = 4;
  // Width of the interrupt identification number
  localparam int unsigned ID_W = 4;

  // Identification numbers follow the service table order
  localparam logic [3:0] ID_RESET = 4'h0;
  localparam logic [3:0] ID_NMI   = 4'h1;
  localparam logic [3:0] ID_EXT4  = 4'h4;

  // Number of cycles the acknowledge strobe stands
  localparam logic [1:0] ACK_CYCLES = 2'h1;

  // Byte-order select values
  localparam logic ORDER_BIG    = 1'b0;
  localparam logic ORDER_LITTLE = 1'b1;

  // Service request from the core: one-cycle pulse with table position
  typedef struct packed {
    logic            valid;
    logic [ID_W-1:0] id;
  } service_s;

  // Acknowledge group driven to the pins
  typedef struct packed {
    logic            ack;
    logic [ID_W-1:0] id;
  } ack_s;

  // Acknowledge sequencer states
  typedef enum logic [0:0] {
    ACK_IDLE,
    ACK_SHOW
  } ack_state_e;

endpackage

// ===== interrupt_and_control_pins.sv
// Interrupt edge capture, acknowledge and control pin logic
//
// Functional notes
// - Only rising edges raise NMI/external requests
// - Pulse acknowledge for every serviced interrupt
// - Identification number valid during acknowledge, all sources
// - Number follows service table position
// - Byte-order pin high little, low big
// - Power-down flag high only in mode 3
`timescale 1ns/1ps

module interrupt_and_control_pins
(
  input  wire logic                         clock,             // Core clock, 200 MHz
  input  wire logic                         nrst,              // Async reset, active low
  input  wire logic                         clk_en,            // Freezes all state when low
  input  wire logic                         nmi_line,          // Nonmaskable interrupt pin
  input  wire logic                         ext_irq_line_4,    // External interrupt pin 4
  input  wire logic                         ext_irq_line_5,    // External interrupt pin 5
  input  wire logic                         ext_irq_line_6,    // External interrupt pin 6
  input  wire logic                         ext_irq_line_7,    // External interrupt pin 7
  input  wire logic                         byte_order_select, // Byte-order pin
  input  wire irq_pins_pkg::service_s       service,           // Core services an interrupt
  input  wire logic                         in_mode3,          // Core is in power-down mode 3
  output logic                              nmi_request,       // One-cycle NMI request
  output logic [irq_pins_pkg::EXT_LINES-1:0] ext_request,      // One-cycle external requests
  output logic                              little_endian,     // Synchronised byte order
  output logic                              irq_service_ack,   // Acknowledge strobe pin
  output logic                              irq_id_bit3,       // Identification bit 3
  output logic                              irq_id_bit2,       // Identification bit 2
  output logic                              irq_id_bit1,       // Identification bit 1
  output logic                              irq_id_bit0,       // Identification bit 0
  output logic                              sleep_mode3_flag   // Power-down mode 3 flag
);

  localparam int unsigned N = irq_pins_pkg::EXT_LINES + 1;

  logic [N-1:0] pins;
  logic [N-1:0] sync1;
  logic [N-1:0] sync2;
  logic [N-1:0] prev;
  logic [N-1:0] req;
  logic [N-1:0] next_sync1;
  logic [N-1:0] next_sync2;
  logic [N-1:0] next_prev;
  logic [N-1:0] next_req;
  logic         ord1;
  logic         ord2;
  logic         next_ord1;
  logic         next_ord2;

  // Bit 0 is NMI, bits above are external lines 4..7
  assign pins = {ext_irq_line_7, ext_irq_line_6, ext_irq_line_5, ext_irq_line_4, nmi_line};

  // Synchroniser and edge detector, one slice per line. A request appears
  // three enabled edges after the pin rises; a pulse shorter than one clock
  // period may fall between samples and be lost
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_line
      always_comb
      begin
        next_sync1[g] = sync1[g];
        next_sync2[g] = sync2[g];
        next_prev[g]  = prev[g];
        next_req[g]   = req[g];
        if (clk_en)
        begin
          next_sync1[g] = pins[g];
          next_sync2[g] = sync1[g];
          next_prev[g]  = sync2[g];
          next_req[g]   = sync2[g] & ~prev[g];
        end
      end

      // Edge history for this line; sync1, sync2 and prev reset high so that a
      // pin already high when reset ends is never taken for a rising edge
      always_ff @(posedge clock or negedge nrst)
      begin
        if (!nrst)
        begin
          sync1[g] <= '1;
          sync2[g] <= '1;
          prev[g]  <= '1;
          req[g]   <= '0;
        end
        else
        begin
          sync1[g] <= next_sync1[g];
          sync2[g] <= next_sync2[g];
          prev[g]  <= next_prev[g];
          req[g]   <= next_req[g];
        end
      end
    end
  endgenerate

  // Byte-order pin is static but still crosses in through two flops
  always_comb
  begin
    next_ord1 = ord1;
    next_ord2 = ord2;
    if (clk_en)
    begin
      next_ord1 = byte_order_select;
      next_ord2 = ord1;
    end
  end

  // Byte-order registers; they come out of reset as big-endian and only
  // follow the pin two edges later
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ord1 <= irq_pins_pkg::ORDER_BIG;
      ord2 <= irq_pins_pkg::ORDER_BIG;
    end
    else
    begin
      ord1 <= next_ord1;
      ord2 <= next_ord2;
    end
  end

  // Requests and byte order leave straight from their registers
  assign nmi_request   = req[0];
  assign ext_request   = req[N-1:1];
  assign little_endian = ord2;

  irq_pins_pkg::ack_state_e state;
  irq_pins_pkg::ack_state_e next_state;
  irq_pins_pkg::ack_s       ack_q;
  irq_pins_pkg::ack_s       next_ack;
  logic                     mode3_q;
  logic                     next_mode3;

  // Acknowledge sequencer: a service pulse shows ack and number together
  always_comb
  begin
    next_state = state;
    next_ack   = ack_q;
    if (clk_en)
    begin
      // A service offered while the strobe stands is dropped, not queued;
      // the core keeps services at least two cycles apart. The number is
      // taken with the strobe and held until the next service
      unique case (state)
        irq_pins_pkg::ACK_IDLE:
        begin
          next_ack.ack = 1'b0;
          if (service.valid)
          begin
            next_ack.ack = 1'b1;
            next_ack.id  = service.id;
            next_state   = irq_pins_pkg::ACK_SHOW;
          end
        end
        irq_pins_pkg::ACK_SHOW:
        begin
          // Number is held after the strobe so it never glitches mid-pulse
          next_ack.ack = 1'b0;
          next_state   = irq_pins_pkg::ACK_IDLE;
        end
      endcase
    end
  end

  // Acknowledge and flag registers feed the pins directly
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= irq_pins_pkg::ACK_IDLE;
      ack_q <= '0;
    end
    else
    begin
      state <= next_state;
      ack_q <= next_ack;
    end
  end

  // Power-down flag: one register stage, so the pin never shows a
  // glitch from the core's mode decode
  always_comb
  begin
    next_mode3 = mode3_q;
    if (clk_en)
    begin
      next_mode3 = in_mode3;
    end
  end

  // Flag register; comes out of reset as not in mode 3
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      mode3_q <= 1'b0;
    end
    else
    begin
      mode3_q <= next_mode3;
    end
  end

  assign irq_service_ack  = ack_q.ack;
  assign irq_id_bit3      = ack_q.id[3];
  assign irq_id_bit2      = ack_q.id[2];
  assign irq_id_bit1      = ack_q.id[1];
  assign irq_id_bit0      = ack_q.id[0];
  assign sleep_mode3_flag = mode3_q;

endmodule // interrupt_and_control_pins

// ===== irq_src_model.sv
// Model of the interrupt sources driving the five edge pins
`timescale 1ns/1ps
module irq_src_model
(
  input  wire logic       clock, // Clock
  input  wire logic [4:0] fire,  // Start a pulse
  output logic      [4:0] pins   // Nmi, then ext 4..7
);
  logic [2:0] hold [5] = '{default: 3'h0};
  // Pins stay high 6 cycles, then low, so the block sees one clean rise and fall
  always_ff @(posedge clock)
    for (int i = 0; i < 5; i++)
      hold[i] <= fire[i] ? 3'h6 : hold[i] - 3'(hold[i] != 3'h0);
  always_comb
    for (int i = 0; i < 5; i++)
      pins[i] = hold[i] != 3'h0;
endmodule // irq_src_model

// ===== irq_pins_checker.sv
// Assertions on the interrupt and control pin block
`timescale 1ns/1ps
module irq_pins_checker
(
  input wire logic                   clock,             // Clock
  input wire logic                   nrst,              // Reset
  input wire logic                   clk_en,            // Enable
  input wire logic                   nmi_line,          // Pin
  input wire logic                   ext_irq_line_4,    // Pin
  input wire logic                   byte_order_select, // Pin
  input wire irq_pins_pkg::service_s service,           // Core
  input wire logic                   in_mode3,          // Core
  input wire logic                   nmi_request,       // Out
  input wire logic [3:0]             ext_request,       // Out
  input wire logic                   little_endian,     // Out
  input wire logic                   irq_service_ack,   // Out
  input wire logic                   irq_id_bit3,       // Out
  input wire logic                   irq_id_bit2,       // Out
  input wire logic                   irq_id_bit1,       // Out
  input wire logic                   irq_id_bit0,       // Out
  input wire logic                   sleep_mode3_flag   // Out
);
  default clocking cb @(posedge clock); endclocking
  // A frozen block keeps its state, so nothing is judged while the enable is low
  default disable iff (!nrst || !clk_en);
  logic [3:0] id;
  // Number gathered from the four pins
  assign id = {irq_id_bit3, irq_id_bit2, irq_id_bit1, irq_id_bit0};
  nmi_rise_a:
    assert property ($rose(nmi_line) |-> ##[3:5] nmi_request) else $error("nmi rise lost");
  ext_rise_a:
    assert property ($rose(ext_irq_line_4) |-> ##[3:5] ext_request[0])
      else $error("ext rise lost");
  // A request comes from the sample pair three and four edges back
  nmi_edge_a:
    assert property (nmi_request |-> $past(nmi_line, 3) && !$past(nmi_line, 4))
      else $error("nmi request without rise");
  ext_edge_a:
    assert property (ext_request[0] |-> $past(ext_irq_line_4, 3) && !$past(ext_irq_line_4, 4))
      else $error("ext request without rise");
  req_once_a:
    assert property (nmi_request |=> !nmi_request) else $error("nmi request repeated");
  ack_take_a:
    assert property (service.valid && !irq_service_ack |=> irq_service_ack
      && id == $past(service.id)) else $error("service not acknowledged");
  ack_once_a:
    assert property (irq_service_ack |=> !irq_service_ack) else $error("ack too long");
  id_hold_a:
    assert property (!irq_service_ack |-> $stable(id)) else $error("id moved without ack");
  // Registered levels restart from their reset values, so skip the edges just after reset
  sleep_flag_a:
    assert property ($past(nrst) |-> sleep_mode3_flag == $past(in_mode3))
      else $error("mode3 flag wrong");
  order_sync_a:
    assert property ($past(nrst) && $past(nrst, 2)
      |-> little_endian == $past(byte_order_select, 2)) else $error("order wrong");
endmodule // irq_pins_checker

bind interrupt_and_control_pins irq_pins_checker irq_pins_checker_i (.clock, .nrst, .clk_en,
  .nmi_line, .ext_irq_line_4, .byte_order_select, .service, .in_mode3, .nmi_request,
  .ext_request, .little_endian, .irq_service_ack, .irq_id_bit3, .irq_id_bit2,
  .irq_id_bit1, .irq_id_bit0, .sleep_mode3_flag);

// ===== interrupt_and_control_pins_tb.sv
// Self-checking bench for the interrupt and control pin block
`timescale 1ns/1ps
module interrupt_and_control_pins_tb;
  logic clock = 0, nrst = 0, order = 0, mode3 = 0, en = 1, ack, le, slp, nreq;
  logic [4:0] fire = '0, pins, req;
  logic [3:0] ereq, id;
  irq_pins_pkg::service_s service = '0;
  int n_fail = 0, tests_run = 0, cyc = 0;
  initial forever #2.5 clock = ~clock;
  assign req = {ereq, nreq};
  irq_src_model irq_src_model_i (.clock(clock), .fire(fire), .pins(pins));
  interrupt_and_control_pins interrupt_and_control_pins_i (.clock(clock), .nrst(nrst),
    .clk_en(en), .nmi_line(pins[0]), .ext_irq_line_4(pins[1]), .ext_irq_line_5(pins[2]),
    .ext_irq_line_6(pins[3]), .ext_irq_line_7(pins[4]), .byte_order_select(order),
    .service(service), .in_mode3(mode3), .nmi_request(nreq), .ext_request(ereq),
    .little_endian(le), .irq_service_ack(ack), .irq_id_bit3(id[3]), .irq_id_bit2(id[2]),
    .irq_id_bit1(id[1]), .irq_id_bit0(id[0]), .sleep_mode3_flag(slp));
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Counts every compare; an unknown fails since ok is tested with case inequality
  task chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("Error %0t %s", $time, m);
    end
  endtask
  // One rise per line: exactly one pulse on its own request, none elsewhere
  task t_edges;
    int c;
    logic [4:0] o;
    for (int i = 0; i < 5; i++)
    begin
      fire[i] = 1'b1;
      step(1);
      fire = '0;
      c = 0;
      o = '0;
      repeat (16)
      begin
        step(1);
        c += int'(req[i] === 1'b1);
        o |= req & ~(5'h01 << i);
      end
      chk(c == 1 && o === 5'h00, "edge count");
    end
    $display("t_edges done");
  endtask
  // Table positions 0, 1, 4 and 15 echoed; a request held into the ack cycle is refused
  task t_ack;
    logic [3:0] ids [4];
    ids = '{irq_pins_pkg::ID_RESET, irq_pins_pkg::ID_NMI, irq_pins_pkg::ID_EXT4, 4'hf};
    foreach (ids[k])
    begin
      service = '{1'b1, ids[k]};
      step(1);
      chk(ack === 1'b1 && id === ids[k], "ack id");
      step(1);
      service.valid = 1'b0;
      chk(ack === 1'b0 && id === ids[k], "ack once");
      step(1);
    end
    $display("t_ack done");
  endtask
  // Byte order lags two edges and the mode-3 flag one, for every pairing of levels
  task t_pins;
    logic was;
    for (int v = 0; v < 4; v++)
    begin
      was = order;
      order = v[0];
      mode3 = v[1];
      step(1);
      chk(slp === v[1] && le === was, "one edge");
      step(1);
      chk(le === v[0], "two edges");
    end
    $display("t_pins done");
  endtask
  // A pin held high across a reset gives no request; reset clears every output
  task t_reset;
    int c;
    fire[0] = 1'b1;
    step(8);
    nrst = 1'b0;
    step(1);
    chk({ack, id, le, slp, req} === 12'h000, "reset clear");
    nrst = 1'b1;
    c = 0;
    repeat (10)
    begin
      step(1);
      c += int'(req[0] === 1'b1);
    end
    chk(c == 0 && le === 1'b1, "held pin after reset");
    fire[0] = 1'b0;
    step(8);
    $display("t_reset done");
  endtask
  // A low enable freezes the sequencer: a service offered then is not taken
  task t_freeze;
    en = 1'b0;
    service = '{1'b1, 4'h5};
    step(1);
    service.valid = 1'b0;
    step(2);
    chk(ack === 1'b0 && id === 4'h0, "frozen ack");
    en = 1'b1;
    step(2);
    chk(ack === 1'b0 && id === 4'h0, "no late ack");
    $display("t_freeze done");
  endtask
  task finish_test;
    $display("Counts: %0d run, %0d failed", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard: the whole run needs well under 400 cycles
  always @(posedge clock)
    if (++cyc == 2000)
    begin
      n_fail++;
      finish_test;
    end
  initial
  begin
    step(3);
    nrst = 1'b1;
    step(2);
    t_edges;
    t_ack;
    t_pins;
    t_reset;
    t_freeze;
    finish_test;
  end
endmodule // interrupt_and_control_pins_tb
